// ### logic/port_mode_pkg.sv
// Shared constants and carrier types for the Type-C port mode control block
package port_mode_pkg;

  // Three-level configuration pin, resolved outside into one of three two-bit codes
  localparam logic [1:0] CFG_LOW   = 2'h0;
  localparam logic [1:0] CFG_HIGH  = 2'h1;
  localparam logic [1:0] CFG_FLOAT = 2'h2;

  // Role configuration strap
  localparam logic [1:0] ROLE_SINK   = 2'h0;
  localparam logic [1:0] ROLE_SOURCE = 2'h1;
  localparam logic [1:0] ROLE_DUAL   = 2'h2;

  // Preferred-role request codes
  localparam logic [1:0] PREF_NONE = 2'h0;
  localparam logic [1:0] PREF_SNK  = 2'h1;
  localparam logic [1:0] PREF_SRC  = 2'h3;

  // Detected current levels
  localparam logic [1:0] CUR_DEFAULT = 2'h0;
  localparam logic [1:0] CUR_MEDIUM  = 2'h1;
  localparam logic [1:0] CUR_HIGH    = 2'h2;

  // Bus target address with bit 6 steered by the strap
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h47;
  localparam int         ADDR_SEL_BIT     = 6;

  // Dual-role presentation toggle period
  localparam int TOGGLE_TIME_US = 50;
  localparam int CLOCK_MHZ      = 25;
  localparam int TOGGLE_CYCLES  = TOGGLE_TIME_US * CLOCK_MHZ;
  localparam int TOGGLE_W       = 12;

  typedef enum logic [2:0] {
    ST_SHUTDOWN   = 3'b000,
    ST_UNATT_SNK  = 3'b001,
    ST_UNATT_SRC  = 3'b011,
    ST_ATT_SRC    = 3'b010,
    ST_ATT_SNK    = 3'b110,
    ST_AUDIO      = 3'b111,
    ST_DEAD       = 3'b101
  } port_state_type;

  // Partner detection from the channel logic
  typedef struct packed {
    logic       partner_sink;   // Pull-down seen while presenting as source
    logic       partner_source; // Pull-up seen while presenting as sink
    logic       audio_acc;      // Audio accessory terminations on both pins
    logic [1:0] current_level;  // Advertised level while sink
  } cc_detect_type;

  // Open-drain pin set: oe low drives the line low
  typedef struct packed {
    logic cur_a_oe;
    logic cur_b_oe;
    logic alert_oe;
    logic attach_oe;
  } od_pins_type;

  typedef struct packed {
    port_state_type       state;
    logic                 strap_done;
    logic                 gpio_mode;
    logic                 addr_bit6;
    logic [TOGGLE_W-1:0]  toggle_cnt;
    logic [2:0]           vbus_sync;
    logic                 vbus_ok;
    logic [2:0]           en_sync;
    logic                 en_ok;
    logic                 alert_flag;
    logic [3:0]           last_status;
    od_pins_type          pins;
    logic                 vconn_en;
    logic                 rd_on_cc;
    logic                 rp_on_cc;
    logic                 regs_active;
  } ctrl_state_type;

endpackage : port_mode_pkg

// ### logic/typec_port_mode_control.sv
// Mode selection, attach state machine and open-drain status outputs
//------------------------------------------------------------------------
// Operation
// [RQ1] Floating configuration pin selects pin-strap control mode.
// [RQ2] Configuration pin high selects register mode, address bit 6 set.
// [RQ3] Configuration pin low selects register mode, address bit 6 clear.
// [RQ4] All outputs are open drain: pull low or release only.
// [RQ5] Pin mode current outputs: HH/HL default, LH medium, LL high.
// [RQ6] Pin mode pulls audio output low while audio accessory attached.
// [RQ7] Register mode pulls alert low when status registers update.
// [RQ8] Asserting alert also sets the pending-alert status flag.
// [RQ9] Host clears pending-alert flag by a register write.
// [RQ10] Bus power sense decides attach, detach, accessory and role.
// [RQ11] Start as unattached sink, follow role strap, toggle if dual-role.
// [RQ12] Unattached keeps I/O and register port alive, cable power off.
// [RQ13] Active source reports attachment on the attach indicator pin.
// [RQ14] Active sink reports via current outputs and alert/audio output.
// [RQ15] Leave active on unplug, sink power loss, supply loss, disable.
// [RQ16] Shutdown stops operation but keeps sink pull-downs on both pins.
// [RQ17] Enable input pulled up; unconnected pin disables the device.
// [RQ18] Missing main supply defaults both pins to sink pull-downs.
// [RQ19] Preferred-role options only in register mode, else plain dual-role.
// [RQ20] Configuration pin sampled once after power-up, then held.
//------------------------------------------------------------------------
`timescale 1ns/1ps

module typec_port_mode_control
  import port_mode_pkg::*;
#(
  parameter int TOGGLE_COUNT = port_mode_pkg::TOGGLE_CYCLES
) (
  input  wire logic                        clock,           // 25 MHz clock
  input  wire logic                        rst_n,           // Async reset, active low
  input  wire logic                        clk_en,          // Freezes state when low
  input  wire logic [1:0]                  cfg_select,      // Resolved three-level pin
  input  wire logic [1:0]                  role_config,     // Role strap
  input  wire logic [1:0]                  pref_role,       // Preferred-role request
  input  wire logic                        main_supply,     // Supply present
  input  wire logic                        cc_enable_n_in,  // Enable pin level, pulled up
  input  wire logic                        bus_power_sense, // Bus power from pin
  input  wire logic                        cable_present,   // Cable seen on channel pins
  input  wire port_mode_pkg::cc_detect_type cc_detect,      // Partner detection
  input  wire logic                        status_update,   // Register contents changed
  input  wire logic                        alert_clear,     // Host write clears flag
  output logic                             current_indicator_a_oe, // Low pulls line low
  output logic                             current_indicator_b_oe, // Low pulls line low
  output logic                             audio_accessory_out_oe, // Alert or audio, low pulls
  output logic                             attach_indicator_pin_oe, // Low pulls line low
  output logic                             gpio_mode,       // Pin-strap mode held
  output logic                             target_addr_bit6, // Bus address bit 6
  output logic [6:0]                       target_addr,     // Full bus target address
  output logic                             alert_pending,   // Pending-alert status flag
  output logic                             vconn_enable,    // Cable power switch
  output logic                             rd_enable,       // Sink pull-downs on both pins
  output logic                             rp_enable,       // Source pull-ups on both pins
  output logic                             regs_active,     // Register port operational
  output logic [2:0]                       port_state       // Current state code
);

  import port_mode_pkg::*;

  ctrl_state_type cur_reg;
  ctrl_state_type cur_next;

  logic presenting_src;
  logic try_src;
  logic try_snk;
  logic disabled;
  logic [3:0] status_now;

  //----------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;

    // Three-stage sync; change counts once stages two and three agree
    cur_next.vbus_sync = {cur_reg.vbus_sync[1:0], bus_power_sense};
    if (cur_reg.vbus_sync[2] == cur_reg.vbus_sync[1]) begin
      cur_next.vbus_ok = cur_reg.vbus_sync[2];
    end
    // Floating enable reads high via pull-up, so it disables
    cur_next.en_sync = {cur_reg.en_sync[1:0], cc_enable_n_in};  // see [RQ17]
    if (cur_reg.en_sync[2] == cur_reg.en_sync[1]) begin
      cur_next.en_ok = ~cur_reg.en_sync[2];
    end

    // One-shot strap capture; only reset re-arms it
    if (!cur_reg.strap_done) begin  // see [RQ20]
      cur_next.strap_done = 1'b1;
      cur_next.gpio_mode  = (cfg_select == CFG_FLOAT);  // see [RQ1]
      cur_next.addr_bit6  = (cfg_select == CFG_HIGH);   // see [RQ2] see [RQ3]
    end

    // Preferred role ignored in pin mode
    try_src = !cur_reg.gpio_mode && (pref_role == PREF_SRC);  // see [RQ19]
    try_snk = !cur_reg.gpio_mode && (pref_role == PREF_SNK);  // see [RQ19]
    disabled = !cur_reg.en_ok;
    presenting_src = 1'b0;

    cur_next.toggle_cnt = cur_reg.toggle_cnt + TOGGLE_W'(1);

    case (cur_reg.state)
      ST_UNATT_SNK: begin
        if (cc_detect.partner_source && cur_reg.vbus_ok) begin  // see [RQ10]
          cur_next.state = cc_detect.audio_acc ? ST_AUDIO : ST_ATT_SNK;
        end else if (cc_detect.audio_acc && cable_present) begin
          cur_next.state = ST_AUDIO;
        end else if (role_config == ROLE_SOURCE) begin  // see [RQ11]
          cur_next.state      = ST_UNATT_SRC;
          cur_next.toggle_cnt = '0;
        end else if (role_config == ROLE_DUAL && !try_snk &&
                     cur_reg.toggle_cnt >= TOGGLE_W'(TOGGLE_COUNT - 1)) begin
          cur_next.state      = ST_UNATT_SRC;
          cur_next.toggle_cnt = '0;
        end
      end
      ST_UNATT_SRC: begin
        presenting_src = 1'b1;
        // Source attaches only once bus power is off, then it enables cable power
        if (cc_detect.partner_sink && !cur_reg.vbus_ok) begin  // see [RQ10]
          cur_next.state = ST_ATT_SRC;
        end else if (cc_detect.audio_acc && cable_present) begin
          cur_next.state = ST_AUDIO;
        end else if (role_config == ROLE_SINK) begin
          cur_next.state      = ST_UNATT_SNK;
          cur_next.toggle_cnt = '0;
        end else if (role_config == ROLE_DUAL && !try_src &&
                     cur_reg.toggle_cnt >= TOGGLE_W'(TOGGLE_COUNT - 1)) begin
          cur_next.state      = ST_UNATT_SNK;
          cur_next.toggle_cnt = '0;
        end
      end
      ST_ATT_SRC: begin
        presenting_src = 1'b1;
        if (!cable_present || !cc_detect.partner_sink) begin  // see [RQ15]
          cur_next.state = ST_UNATT_SNK;
        end
      end
      ST_ATT_SNK: begin
        if (!cable_present || !cur_reg.vbus_ok) begin  // see [RQ15]
          cur_next.state = ST_UNATT_SNK;
        end
      end
      ST_AUDIO: begin
        if (!cable_present || !cc_detect.audio_acc) begin  // see [RQ10]
          cur_next.state = ST_UNATT_SNK;
        end
      end
      ST_SHUTDOWN, ST_DEAD: begin
        cur_next.state      = ST_UNATT_SNK;  // see [RQ11]
        cur_next.toggle_cnt = '0;
      end
      default: begin
        cur_next.state = ST_UNATT_SNK;
      end
    endcase

    // Supply loss and disable override everything
    if (!main_supply) begin
      cur_next.state = ST_DEAD;  // see [RQ15] see [RQ18]
    end else if (disabled) begin
      cur_next.state = ST_SHUTDOWN;  // see [RQ15] see [RQ16]
    end

    // Status snapshot; any change counts as a register update
    status_now = {cur_reg.state == ST_ATT_SNK, cur_reg.state == ST_ATT_SRC,
                  cur_reg.state == ST_AUDIO, cur_reg.vbus_ok};
    cur_next.last_status = status_now;
    // Set wins over a clear in the same cycle
    if (alert_clear) begin  // see [RQ9]
      cur_next.alert_flag = 1'b0;
    end
    if (!cur_reg.gpio_mode && cur_reg.regs_active &&
        (status_update || status_now != cur_reg.last_status)) begin
      cur_next.alert_flag = 1'b1;  // see [RQ7] see [RQ8]
    end
    if (cur_reg.gpio_mode) begin
      cur_next.alert_flag = 1'b0;
    end

    // Open-drain drive: oe low pulls the line low, high releases
    cur_next.pins = '{default: 1'b1};  // see [RQ4]
    if (cur_reg.gpio_mode && cur_reg.state == ST_ATT_SNK) begin  // see [RQ14]
      case (cc_detect.current_level)  // see [RQ5]
        CUR_MEDIUM: begin
          cur_next.pins.cur_a_oe = 1'b0;
        end
        CUR_HIGH: begin
          cur_next.pins.cur_a_oe = 1'b0;
          cur_next.pins.cur_b_oe = 1'b0;
        end
        default: begin
          cur_next.pins.cur_a_oe = 1'b1;
        end
      endcase
    end
    if (cur_reg.gpio_mode) begin
      cur_next.pins.alert_oe = !(cur_reg.state == ST_AUDIO);  // see [RQ6] see [RQ14]
    end else begin
      cur_next.pins.alert_oe = !cur_next.alert_flag;  // see [RQ7]
    end
    cur_next.pins.attach_oe = !(cur_reg.state == ST_ATT_SRC);  // see [RQ13]

    // Terminations and supplies
    cur_next.vconn_en = (cur_next.state == ST_ATT_SRC);  // see [RQ12]
    cur_next.rp_on_cc = (cur_next.state == ST_UNATT_SRC) || (cur_next.state == ST_ATT_SRC);
    cur_next.rd_on_cc = !cur_next.rp_on_cc;  // see [RQ16] see [RQ18]
    cur_next.regs_active = !(cur_next.state == ST_SHUTDOWN || cur_next.state == ST_DEAD);  // see [RQ12]
    if (presenting_src && !cur_reg.rp_on_cc) begin
      cur_next.rp_on_cc = 1'b1;
    end
  end

  //----------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '{state:       ST_UNATT_SNK,
                   strap_done:  1'b0,
                   gpio_mode:   1'b1,
                   addr_bit6:   1'b0,
                   toggle_cnt:  '0,
                   vbus_sync:   3'h0,
                   vbus_ok:     1'b0,
                   en_sync:     3'h7,
                   en_ok:       1'b0,
                   alert_flag:  1'b0,
                   last_status: 4'h0,
                   pins:        '{default: 1'b1},
                   vconn_en:    1'b0,
                   rd_on_cc:    1'b1,
                   rp_on_cc:    1'b0,
                   regs_active: 1'b1};
    end else if (clk_en) begin
      cur_reg <= cur_next;
    end
  end

  //----------------------------------------------------------------------
  // Outputs, all straight from the state register
  //----------------------------------------------------------------------
  always_comb begin
    target_addr = TARGET_ADDR_BASE;
    target_addr[ADDR_SEL_BIT] = cur_reg.addr_bit6;
  end

  assign current_indicator_a_oe  = cur_reg.pins.cur_a_oe;
  assign current_indicator_b_oe  = cur_reg.pins.cur_b_oe;
  assign audio_accessory_out_oe  = cur_reg.pins.alert_oe;
  assign attach_indicator_pin_oe = cur_reg.pins.attach_oe;
  assign gpio_mode               = cur_reg.gpio_mode;
  assign target_addr_bit6        = cur_reg.addr_bit6;
  assign alert_pending           = cur_reg.alert_flag;
  assign vconn_enable            = cur_reg.vconn_en;
  assign rd_enable               = cur_reg.rd_on_cc;
  assign rp_enable               = cur_reg.rp_on_cc;
  assign regs_active             = cur_reg.regs_active;
  assign port_state              = cur_reg.state;

endmodule : typec_port_mode_control

// ### tb/port_partner_model.sv
// Behavioural port partner: terminations, advertised level and bus power
`timescale 1ns/1ps
module port_partner_model
  import port_mode_pkg::*;
(
  input  wire logic [1:0]             kind,            // 0 none, 1 source, 2 sink, 3 audio
  input  wire logic [1:0]             level,           // Advertised current
  input  wire logic                   rd_enable,       // Our pull-downs on
  input  wire logic                   rp_enable,       // Our pull-ups on
  output port_mode_pkg::cc_detect_type cc_detect,      // What the channel sees
  output logic                        cable_present,   // Plug inserted
  output logic                        bus_power_sense  // Partner bus power
);
  // A sink or source partner only shows up against the opposite termination
  assign cable_present = (kind != 2'h0);
  assign bus_power_sense = (kind == 2'h1);
  // One driver for the whole struct: sink seen, source seen, audio, level
  assign cc_detect = {(kind == 2'h2) && rp_enable, (kind == 2'h1) && rd_enable, kind == 2'h3,
                      (kind == 2'h1) ? level : CUR_DEFAULT};
endmodule : port_partner_model

// ### tb/typec_port_mode_control_asserts.sv
// Concurrent checks on the port mode control outputs
`timescale 1ns/1ps
module typec_port_mode_control_asserts
  import port_mode_pkg::*;
#(
  parameter int TOGGLE_COUNT = 8
) (
  input wire logic                          clock,                  // Clock
  input wire logic                          rst_n,                  // Reset
  input wire logic                          clk_en,                 // Run
  input wire logic [1:0]                    cfg_select,             // Strap
  input wire logic                          main_supply,            // Supply
  input wire logic                          cc_enable_n_in,         // Enable pin
  input wire port_mode_pkg::cc_detect_type  cc_detect,              // Detection
  input wire logic                          status_update,          // Update
  input wire logic                          current_indicator_a_oe, // Current a
  input wire logic                          current_indicator_b_oe, // Current b
  input wire logic                          audio_accessory_out_oe, // Alert/audio
  input wire logic                          attach_indicator_pin_oe, // Attach
  input wire logic                          gpio_mode,              // Pin mode
  input wire logic                          target_addr_bit6,       // Address bit
  input wire logic [6:0]                    target_addr,            // Address
  input wire logic                          alert_pending,          // Flag
  input wire logic                          vconn_enable,           // Cable power
  input wire logic                          rd_enable,              // Pull-downs
  input wire logic                          regs_active,            // Register port
  input wire logic [2:0]                    port_state              // State
);
  //----------------------------------------
  // Properties
  //----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_strap_float; $rose(rst_n) && clk_en && cfg_select == CFG_FLOAT |=> gpio_mode; endproperty
  property p_strap_reg;
    $rose(rst_n) && clk_en && cfg_select != CFG_FLOAT |=> !gpio_mode
      && target_addr_bit6 == ($past(cfg_select) == CFG_HIGH) && target_addr == {target_addr_bit6, TARGET_ADDR_BASE[5:0]};
  endproperty
  // Strap is taken once; the first two edges after release still see reset
  property p_strap_hold; rst_n && $past(rst_n, 2) |-> $stable(gpio_mode) && $stable(target_addr); endproperty
  // A frozen clock enable holds the flag, so only enabled edges count
  property p_alert_set;
    clk_en && !gpio_mode && regs_active && status_update |=> alert_pending && !audio_accessory_out_oe;
  endproperty
  property p_audio_out; gpio_mode && port_state == ST_AUDIO && $past(port_state) == ST_AUDIO |-> !audio_accessory_out_oe;
  endproperty
  property p_cur_code;
    gpio_mode && port_state == ST_ATT_SNK && $past(port_state) == ST_ATT_SNK && $stable(cc_detect) |->
      current_indicator_a_oe == (cc_detect.current_level == CUR_DEFAULT)
      && current_indicator_b_oe == (cc_detect.current_level != CUR_HIGH);
  endproperty
  property p_src_report; port_state == ST_ATT_SRC && $past(port_state) == ST_ATT_SRC |-> !attach_indicator_pin_oe;
  endproperty
  property p_unatt; port_state inside {ST_UNATT_SNK, ST_UNATT_SRC} |-> !vconn_enable && regs_active; endproperty
  property p_off_rd; port_state inside {ST_SHUTDOWN, ST_DEAD} |-> rd_enable && !vconn_enable; endproperty
  property p_dead; !main_supply && !cc_enable_n_in |-> ##[1:3] port_state == ST_DEAD; endproperty
  property p_disable; (main_supply && cc_enable_n_in)[*5] |-> ##[0:3] port_state == ST_SHUTDOWN; endproperty

  a_strap_float: assert property (p_strap_float) else $error("pin mode not taken");
  a_strap_reg: assert property (p_strap_reg) else $error("register mode strap wrong");
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");
  a_alert_set: assert property (p_alert_set) else $error("alert not raised");
  a_audio_out: assert property (p_audio_out) else $error("audio output not low");
  a_cur_code: assert property (p_cur_code) else $error("current outputs wrong");
  a_src_report: assert property (p_src_report) else $error("attach pin not low");
  a_unatt: assert property (p_unatt) else $error("unattached outputs wrong");
  a_off_rd: assert property (p_off_rd) else $error("pull-downs missing");
  a_dead: assert property (p_dead) else $error("supply loss not seen");
  a_disable: assert property (p_disable) else $error("disable not seen");

  c_att_snk: cover property (port_state == ST_ATT_SNK);
  c_att_src: cover property (port_state == ST_ATT_SRC);
  c_audio: cover property (port_state == ST_AUDIO);
endmodule : typec_port_mode_control_asserts

bind typec_port_mode_control typec_port_mode_control_asserts #(.TOGGLE_COUNT(TOGGLE_COUNT))
  typec_port_mode_control_asserts_inst (.*);

// ### tb/typec_port_mode_control_tb.sv
// Self-checking bench for the Type-C port mode control block
`timescale 1ns/1ps
module typec_port_mode_control_tb;
  import port_mode_pkg::*;
  typedef struct packed {
    logic [1:0]     cfg;
    logic [1:0]     role;
    logic [1:0]     kind;
    logic [1:0]     lvl;
    port_state_type st;
    logic [3:0]     oe;  // Current a, current b, audio, attach
  } row_type;
  logic clock, rst_n, clk_en, main_supply, cc_enable_n_in, status_update, alert_clear;
  logic [1:0] cfg_select, role_config, pref_role, kind, level;
  logic current_indicator_a_oe, current_indicator_b_oe, audio_accessory_out_oe, attach_indicator_pin_oe;
  logic gpio_mode, target_addr_bit6, alert_pending, vconn_enable, rd_enable, rp_enable, regs_active;
  logic cable_present, bus_power_sense;
  logic [6:0] target_addr;
  logic [2:0] port_state;
  logic [3:0] pins_oe;
  cc_detect_type cc_detect;
  int err_count, checks_done;
  logic seen_src, seen_snk;
  row_type rows [7] = '{
    '{CFG_FLOAT, ROLE_SINK, 2'h1, CUR_DEFAULT, ST_ATT_SNK, 4'hf},
    '{CFG_FLOAT, ROLE_SINK, 2'h1, CUR_MEDIUM, ST_ATT_SNK, 4'h7},
    '{CFG_FLOAT, ROLE_SINK, 2'h1, CUR_HIGH, ST_ATT_SNK, 4'h3},
    '{CFG_FLOAT, ROLE_DUAL, 2'h3, CUR_DEFAULT, ST_AUDIO, 4'hd},
    '{CFG_FLOAT, ROLE_SOURCE, 2'h2, CUR_DEFAULT, ST_ATT_SRC, 4'he},
    '{CFG_HIGH, ROLE_SOURCE, 2'h2, CUR_DEFAULT, ST_ATT_SRC, 4'he},
    '{CFG_LOW, ROLE_DUAL, 2'h1, CUR_MEDIUM, ST_ATT_SNK, 4'hf}
  };
  assign pins_oe = {current_indicator_a_oe, current_indicator_b_oe, audio_accessory_out_oe, attach_indicator_pin_oe};

  typec_port_mode_control #(.TOGGLE_COUNT(8)) typec_port_mode_control_inst (.*);
  port_partner_model port_partner_model_inst (.kind, .level, .rd_enable, .rp_enable, .cc_detect, .cable_present,
    .bus_power_sense);

  //----------------------------------------
  // Tasks
  //----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    while (port_state !== s && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n == 400) begin
      err_count++;
      give_verdict();
    end
  endtask : wait_state
  task automatic do_reset(input logic [1:0] cfg);
    @(negedge clock);
    rst_n = 0;
    cfg_select = cfg;
    repeat (10) @(negedge clock);
    rst_n = 1;
    repeat (6) @(negedge clock);
  endtask : do_reset
  task automatic pulse(input logic set, input logic clr);
    @(negedge clock);
    status_update = set;
    alert_clear = clr;
    @(negedge clock);
    status_update = 0;
    alert_clear = 0;
    @(negedge clock);
  endtask : pulse
  task automatic watch();
    seen_src = 0;
    seen_snk = 0;
    repeat (60) begin
      @(negedge clock);
      if (port_state === ST_UNATT_SRC) seen_src = 1;
      if (port_state === ST_UNATT_SNK) seen_snk = 1;
    end
  endtask : watch

  //----------------------------------------
  // Stimulus
  //----------------------------------------
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  initial begin
    rst_n = 0;
    clk_en = 1;
    cfg_select = CFG_FLOAT;
    pref_role = PREF_NONE;
    main_supply = 1;
    cc_enable_n_in = 0;
    status_update = 0;
    alert_clear = 0;
    err_count = 0;
    checks_done = 0;
    foreach (rows[i]) begin
      role_config = rows[i].role;
      kind = rows[i].kind;
      level = rows[i].lvl;
      do_reset(rows[i].cfg);
      wait_state(rows[i].st);
      repeat (3) @(negedge clock);
      check(gpio_mode, rows[i].cfg == CFG_FLOAT);
      check(target_addr, {rows[i].cfg == CFG_HIGH, TARGET_ADDR_BASE[5:0]});
      if (rows[i].cfg == CFG_FLOAT) begin
        check(pins_oe, rows[i].oe);
      end else begin
        check(attach_indicator_pin_oe, rows[i].oe[0]);
      end
    end
    // Fixed sink role keeps the port from toggling to source, so rp_enable stays low
    role_config = ROLE_SINK;
    kind = 2'h0;
    wait_state(ST_UNATT_SNK);
    repeat (3) @(negedge clock);
    check({vconn_enable, regs_active, rp_enable}, 3'b010);
    pulse(1'b0, 1'b1);
    check(alert_pending, 1'b0);
    pulse(1'b1, 1'b0);
    check({alert_pending, audio_accessory_out_oe}, 2'b10);
    pulse(1'b1, 1'b1);
    check(alert_pending, 1'b1);
    pulse(1'b0, 1'b1);
    check({alert_pending, audio_accessory_out_oe}, 2'b01);
    // Clock enable low must freeze the flag too
    clk_en = 0;
    pulse(1'b1, 1'b0);
    check(alert_pending, 1'b0);
    clk_en = 1;
    cfg_select = CFG_FLOAT;
    repeat (3) @(negedge clock);
    check(gpio_mode, 1'b0);
    main_supply = 0;
    wait_state(ST_DEAD);
    check(rd_enable, 1'b1);
    main_supply = 1;
    wait_state(ST_UNATT_SNK);
    cc_enable_n_in = 1;
    wait_state(ST_SHUTDOWN);
    check(rd_enable, 1'b1);
    cc_enable_n_in = 0;
    role_config = ROLE_DUAL;
    pref_role = PREF_SRC;
    do_reset(CFG_FLOAT);
    watch();
    check({seen_src, seen_snk}, 2'b11);
    pulse(1'b1, 1'b0);
    check(alert_pending, 1'b0);
    pref_role = PREF_SNK;
    do_reset(CFG_HIGH);
    watch();
    check(seen_src, 1'b0);
    give_verdict();
  end
endmodule : typec_port_mode_control_tb
